//--- hdl/ifd_decoder.sv
// instruction format and operand decoder with general registers and halfword memory port
`timescale 1ns/100ps
module ifd_decoder (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // halfword memory port
    output logic mem_rd_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // decode results
    output logic decode_done,
    output logic fp_sel,
    output logic [3:0] fp_reg_sel
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ifd_pkg::ifd_state_t st;
        logic [31:0] instr;
        logic [3:0] cls;
        logic [1:0] size;
        logic [1:0] fmt;
        logic [15:0] status_word;
        logic [15:0] loc;
        logic [15:0] ea;
        logic [15:0] addr;
        logic [15:0] opnd1;
        logic [31:0] opnd2;
        logic [15:0] opnd3;
        logic [15:0] next_loc;
        logic [15:0] target;
        logic [2:0] warn;
        logic done;
        logic fp_sel;
        logic [3:0] fp_reg;
        logic [31:0] rdata;
        logic [15:0][15:0] gr;
    } ifd_regs_t;

    ifd_regs_t q;
    ifd_regs_t d;

    logic [7:0] function_code;
    logic [3:0] first_field;
    logic [3:0] second_field;
    logic [15:0] memory_pointer_field;

    // leftmost bit is bit zero: function code occupies the top byte
    assign function_code = q.instr[31:24];
    assign first_field = q.instr[23:20];
    assign second_field = q.instr[19:16];
    assign memory_pointer_field = q.instr[15:0];

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] ifd_index(input logic [3:0] sel,
                                              input logic [15:0][15:0] gr);
        // register zero never indexes
        ifd_index = (sel != 4'h0) ? gr[sel] : 16'h0000;
    endfunction : ifd_index

    function automatic logic [15:0] ifd_align(input logic [15:0] a,
                                              input logic [1:0] size);
        // halfword and fullword drop to the even address below
        ifd_align = (size == ifd_pkg::SZ_BYTE) ? a : {a[15:1], 1'b0};
    endfunction : ifd_align

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] r1;
        logic [3:0] r2;
        logic [15:0] ea;
        logic [7:0] widx;
        r1 = first_field;
        r2 = second_field;
        ea = 16'(memory_pointer_field + ifd_index(r2, q.gr));
        widx = 8'h00;
        d = q;
        case (q.st)
            ifd_pkg::ST_IDLE: begin
            end
            ifd_pkg::ST_DECODE: begin
                d.ea = ea;
                d.warn = 3'b000;
                d.fp_sel = 1'b0;
                d.fp_reg = 4'h0;
                d.opnd1 = q.gr[r1];
                d.opnd3 = 16'h0000;
                d.target = q.loc;
                if (q.fmt == ifd_pkg::FMT_RR || q.fmt == ifd_pkg::FMT_SF) begin
                    d.next_loc = 16'(q.loc + ifd_pkg::STEP_HALF);
                end else begin
                    d.next_loc = 16'(q.loc + ifd_pkg::STEP_FULL);
                end
                d.st = ifd_pkg::ST_DONE;
                case (q.fmt)
                    ifd_pkg::FMT_RR: begin
                        d.opnd2 = {16'h0000, q.gr[r2]};
                    end
                    ifd_pkg::FMT_RX: begin
                        d.addr = ifd_align(ea, q.size);
                        d.st = ifd_pkg::ST_FETCH_HI;
                    end
                    ifd_pkg::FMT_RS: begin
                        d.opnd2 = {16'h0000, ea};
                    end
                    default: begin
                        // short data: immediate, shift count or halfword displacement
                        d.opnd2 = {28'h0000_000, r2};
                        d.target = 16'(q.loc + {11'h000, r2, 1'b0});
                    end
                endcase
                case (q.cls)
                    ifd_pkg::CLS_BRANCH_COND: begin
                        d.opnd1 = {12'h000, r1 & q.status_word[3:0]};
                    end
                    ifd_pkg::CLS_IO: begin
                        d.opnd1 = q.gr[r1];
                    end
                    ifd_pkg::CLS_SVC: begin
                        d.opnd1 = {12'h000, r1};
                    end
                    ifd_pkg::CLS_ZERO_R1: begin
                        d.warn[2] = (r1 != 4'h0);
                    end
                    ifd_pkg::CLS_EVEN_R1: begin
                        d.warn[0] = r1[0];
                    end
                    ifd_pkg::CLS_BRANCH_INDEX: begin
                        d.opnd3 = q.gr[4'(r1 + 4'h2)];
                        d.opnd2[31:16] = q.gr[4'(r1 + 4'h1)];
                        d.warn[1] = (r1 > ifd_pkg::BXH_MAX_R1);
                    end
                    ifd_pkg::CLS_FLOAT: begin
                        d.opnd1 = 16'h0000;
                        d.fp_sel = 1'b1;
                        d.fp_reg = r1;
                        d.warn[0] = r1[0];
                    end
                    ifd_pkg::CLS_EXCHANGE: begin
                        d.gr[r1] = q.status_word;
                        if (r1 != r2) begin
                            d.status_word = q.gr[r2];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            ifd_pkg::ST_FETCH_HI: begin
                if (mem_ack) begin
                    case (q.size)
                        ifd_pkg::SZ_BYTE: begin
                            // even address is the left byte
                            d.opnd2 = {24'h0000_00, q.ea[0] ? mem_rdata[7:0]
                                                            : mem_rdata[15:8]};
                            d.st = ifd_pkg::ST_DONE;
                        end
                        ifd_pkg::SZ_FULL: begin
                            d.opnd2[31:16] = mem_rdata;
                            d.addr = 16'(q.addr + ifd_pkg::STEP_HALF);
                            d.st = ifd_pkg::ST_FETCH_LO;
                        end
                        default: begin
                            d.opnd2 = {16'h0000, mem_rdata};
                            d.st = ifd_pkg::ST_DONE;
                        end
                    endcase
                end
            end
            ifd_pkg::ST_FETCH_LO: begin
                if (mem_ack) begin
                    d.opnd2[15:0] = mem_rdata;
                    d.st = ifd_pkg::ST_DONE;
                end
            end
            ifd_pkg::ST_DONE: begin
                d.done = 1'b1;
                d.loc = q.next_loc;
                d.st = ifd_pkg::ST_IDLE;
            end
            default: begin
                d.st = ifd_pkg::ST_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // register port
        // --------------------------------------------------------
        d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                ifd_pkg::OFS_INSTR: d.rdata = q.instr;
                ifd_pkg::OFS_CMD: d.rdata = {8'h00, function_code, 8'h00,
                                            (q.st != ifd_pkg::ST_IDLE), q.done,
                                            q.warn, q.fp_sel, 2'b00};
                ifd_pkg::OFS_STATUS_WORD: d.rdata = {16'h0000, q.status_word};
                ifd_pkg::OFS_LOC: d.rdata = {16'h0000, q.loc};
                ifd_pkg::OFS_OPND1: d.rdata = {16'h0000, q.opnd1};
                ifd_pkg::OFS_OPND2: d.rdata = q.opnd2;
                ifd_pkg::OFS_OPND3: d.rdata = {16'h0000, q.opnd3};
                ifd_pkg::OFS_FLOW: d.rdata = {q.target, q.next_loc};
                default: begin
                    if (reg_addr[7:6] == ifd_pkg::OFS_GR_BASE[7:6] && reg_addr[1:0] == 2'b00) begin
                        d.rdata = {16'h0000, q.gr[reg_addr[5:2]]};
                    end
                end
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                ifd_pkg::OFS_INSTR: d.instr = reg_wdata;
                ifd_pkg::OFS_CMD: begin
                    // a new command is taken only while idle
                    if (q.st == ifd_pkg::ST_IDLE) begin
                        d.cls = reg_wdata[ifd_pkg::CMD_CLS_LSB +: 4];
                        d.size = reg_wdata[ifd_pkg::CMD_SIZE_LSB +: 2];
                        d.fmt = reg_wdata[ifd_pkg::CMD_FMT_LSB +: 2];
                        d.done = 1'b0;
                        d.st = ifd_pkg::ST_DECODE;
                    end
                end
                ifd_pkg::OFS_STATUS_WORD: d.status_word = reg_wdata[15:0];
                ifd_pkg::OFS_LOC: d.loc = reg_wdata[15:0];
                default: begin
                    if (reg_addr[7:6] == ifd_pkg::OFS_GR_BASE[7:6] && reg_addr[1:0] == 2'b00) begin
                        widx = {4'h0, reg_addr[5:2]};
                        d.gr[widx[3:0]] = reg_wdata[15:0];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
            q.st <= ifd_pkg::ST_IDLE;
            q.status_word <= ifd_pkg::PSW_RESET;
            q.loc <= ifd_pkg::LOC_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = q.rdata;
    assign mem_rd_req = (q.st == ifd_pkg::ST_FETCH_HI) || (q.st == ifd_pkg::ST_FETCH_LO);
    assign mem_addr = q.addr;
    assign decode_done = (q.st == ifd_pkg::ST_DONE);
    assign fp_sel = q.fp_sel;
    assign fp_reg_sel = q.fp_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic in_decode;
    logic psw_wr;
    assign in_decode = (q.st == ifd_pkg::ST_DECODE);
    assign psw_wr = reg_wr && (reg_addr == ifd_pkg::OFS_STATUS_WORD);

    a_short_step: assert property (@(posedge ref_clk) disable iff (reset)
        in_decode && q.fmt == ifd_pkg::FMT_SF |=> ##1 q.loc == 16'($past(q.loc, 2) + 16'h0002)
        || $past(reg_wr))
        else $error("short form did not advance location by 2");
    a_align_fetch: assert property (@(posedge ref_clk) disable iff (reset)
        mem_rd_req && q.size != ifd_pkg::SZ_BYTE |-> mem_addr[0] == 1'b0)
        else $error("odd halfword fetch address");
    a_full_second: assert property (@(posedge ref_clk) disable iff (reset)
        q.st == ifd_pkg::ST_FETCH_HI && mem_ack && q.size == ifd_pkg::SZ_FULL
        |=> mem_rd_req && mem_addr == 16'($past(mem_addr) + 16'h0002))
        else $error("second halfword not at address plus 2");
    a_no_index: assert property (@(posedge ref_clk) disable iff (reset)
        in_decode && q.fmt == ifd_pkg::FMT_RS && second_field == 4'h0
        |=> q.opnd2[15:0] == $past(memory_pointer_field))
        else $error("zero index selector modified the address");
    a_svc_literal: assert property (@(posedge ref_clk) disable iff (reset)
        in_decode && q.cls == ifd_pkg::CLS_SVC |=> q.opnd1 == {12'h000, $past(first_field)})
        else $error("call type is not the literal first field");
    a_mask_and: assert property (@(posedge ref_clk) disable iff (reset)
        in_decode && q.cls == ifd_pkg::CLS_BRANCH_COND
        |=> q.opnd1 == {12'h000, $past(first_field) & $past(q.status_word[3:0])})
        else $error("condition mask not ANDed with condition code");
    a_exch_same: assert property (@(posedge ref_clk) disable iff (reset)
        in_decode && q.cls == ifd_pkg::CLS_EXCHANGE && first_field == second_field && !psw_wr
        |=> q.status_word == $past(q.status_word))
        else $error("status changed on exchange with equal fields");
    a_fp_route: assert property (@(posedge ref_clk) disable iff (reset)
        in_decode && q.cls == ifd_pkg::CLS_FLOAT |=> fp_sel && fp_reg_sel == $past(first_field))
        else $error("float first field not routed to float file");
    a_half_data: assert property (@(posedge ref_clk) disable iff (reset)
        q.st == ifd_pkg::ST_FETCH_HI && mem_ack && q.size == ifd_pkg::SZ_HALF
        |=> decode_done && q.opnd2 == {16'h0000, $past(mem_rdata)})
        else $error("halfword operand not taken whole");

endmodule : ifd_decoder

//--- hdl/ifd_pkg.sv
// package of constants and types for the instruction format and operand decoder
package ifd_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS_WORD = 8'h08;
    localparam logic [7:0] OFS_LOC = 8'h0C;
    localparam logic [7:0] OFS_OPND1 = 8'h10;
    localparam logic [7:0] OFS_OPND2 = 8'h14;
    localparam logic [7:0] OFS_OPND3 = 8'h18;
    localparam logic [7:0] OFS_FLOW = 8'h1C;
    localparam logic [7:0] OFS_GR_BASE = 8'h40;

    // ------------------------------------------------------------
    // command fields, formats, sizes, classes
    // ------------------------------------------------------------
    localparam int CMD_CLS_LSB = 0;
    localparam int CMD_SIZE_LSB = 4;
    localparam int CMD_FMT_LSB = 6;
    localparam logic [1:0] FMT_RR = 2'h0;
    localparam logic [1:0] FMT_RX = 2'h1;
    localparam logic [1:0] FMT_RS = 2'h2;
    localparam logic [1:0] FMT_SF = 2'h3;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_FULL = 2'h2;
    localparam logic [3:0] CLS_PLAIN = 4'h0;
    localparam logic [3:0] CLS_BRANCH_COND = 4'h1;
    localparam logic [3:0] CLS_IO = 4'h2;
    localparam logic [3:0] CLS_SVC = 4'h3;
    localparam logic [3:0] CLS_ZERO_R1 = 4'h4;
    localparam logic [3:0] CLS_EVEN_R1 = 4'h5;
    localparam logic [3:0] CLS_BRANCH_INDEX = 4'h6;
    localparam logic [3:0] CLS_FLOAT = 4'h7;
    localparam logic [3:0] CLS_EXCHANGE = 4'h8;

    // ------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] STEP_HALF = 16'h0002;
    localparam logic [15:0] STEP_FULL = 16'h0004;
    localparam logic [3:0] BXH_MAX_R1 = 4'hD;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [15:0] LOC_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_FETCH_HI = 3'b011,
        ST_FETCH_LO = 3'b010,
        ST_DONE = 3'b110
    } ifd_state_t;

endpackage : ifd_pkg

//--- tb/ifd_mem_model.sv
// halfword core memory model that answers decoder reads after a set wait
`timescale 1ns/100ps
module ifd_mem_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // halfword memory port
    input wire logic mem_rd_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    // answer delay in cycles
    input wire logic [3:0] wait_cycles
);
    logic [3:0] wait_q;
    logic [7:0] spin_q;

    // byte per address; 0050..0057 hold 01 23 45 67 89 ab cd ef
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        logic [7:0] base;
        base = 8'h01 + 8'h22 * {5'h00, a[2:0]};
        return (a[15:3] == 13'h000A) ? base : base ^ a[10:3];
    endfunction : mem_byte

    assign mem_ack = mem_rd_req && (wait_q == wait_cycles);
    // even address byte on the left, odd on the right; pattern whenever mem_ack is low
    assign mem_rdata = mem_ack ? {mem_byte(mem_addr & 16'hFFFE), mem_byte(mem_addr | 16'h0001)}
                               : ~{spin_q, spin_q};

    always_ff @(posedge ref_clk) begin
        spin_q <= reset ? 8'h00 : spin_q + 8'h01;
        if (reset || !mem_rd_req || mem_ack) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : ifd_mem_model

//--- tb/testbench.sv
// self-checking testbench for the instruction format and operand decoder
`timescale 1ns/100ps
module testbench;
    localparam logic [31:0] F = 32'hFFFF_FFFF;
    localparam logic [31:0] H = 32'h0000_FFFF;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic mem_rd_req, mem_ack, decode_done, fp_sel;
    logic [15:0] mem_addr, mem_rdata;
    logic [3:0] fp_reg_sel;
    logic [3:0] wait_cycles = 4'h0;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] rx_ins [6] = '{32'h4109_0059, 32'h4109_0059, 32'h4109_0059,
                                32'h4100_0050, 32'h4100_0050, 32'h4100_0053};
    logic [1:0] rx_sz [6] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1};
    logic [31:0] rx_exp [6] = '{32'h89AB_CDEF, 32'h0000_89AB, 32'h0000_00AB,
                                32'h0123_4567, 32'h0000_0001, 32'h0000_4567};

    always #5 ref_clk = ~ref_clk;

    ifd_decoder dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .decode_done(decode_done), .fp_sel(fp_sel),
        .fp_reg_sel(fp_reg_sel));

    ifd_mem_model mem (.ref_clk(ref_clk), .reset(reset), .mem_rd_req(mem_rd_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .wait_cycles(wait_cycles));

    function automatic logic [31:0] gv(input int i);
        return {16'h0000, 4'hA, 4'(i), ~4'(i), 4'(i)};
    endfunction : gv

    function automatic logic [7:0] gra(input int i);
        return 8'(ifd_pkg::OFS_GR_BASE + 4 * i);
    endfunction : gra

    // ------------------------------------------------------------
    // register port tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                      input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata & m, exp);
    endtask : rd

    task automatic dec(input logic [31:0] ins, input logic [3:0] cls, input logic [1:0] sz,
                       input logic [1:0] fmt);
        int n;
        wr(ifd_pkg::OFS_INSTR, ins);
        wr(ifd_pkg::OFS_CMD, 32'({fmt, sz, cls}));
        n = 0;
        while (decode_done !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 40) chk("decode_done", 32'h0000_0000, 32'h0000_0001);
    endtask : dec

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ifd_pkg::OFS_STATUS_WORD, F, 32'h0000_0000, "status reset");
        rd(ifd_pkg::OFS_LOC, F, 32'h0000_0000, "loc reset");
        for (int i = 0; i < 16; i++) wr(gra(i), 32'hFFFF_0000 | gv(i));
        rd(gra(3), F, gv(3), "gr width");
        dec(32'h1A35_0000, ifd_pkg::CLS_PLAIN, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_OPND1, H, gv(3), "rr opnd1");
        rd(ifd_pkg::OFS_OPND2, H, gv(5), "rr opnd2");
        rd(ifd_pkg::OFS_LOC, H, 32'h0000_0002, "rr loc");
        rd(ifd_pkg::OFS_CMD, 32'h00FF_0000, 32'h001A_0000, "function code");
        dec(32'h2B47_0000, ifd_pkg::CLS_PLAIN, ifd_pkg::SZ_HALF, ifd_pkg::FMT_SF);
        rd(ifd_pkg::OFS_OPND2, H, 32'h0000_0007, "sf data");
        rd(ifd_pkg::OFS_FLOW, F, 32'h0010_0004, "sf target");
        dec(32'h3360_1234, ifd_pkg::CLS_PLAIN, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RS);
        rd(ifd_pkg::OFS_OPND2, H, 32'h0000_1234, "rs no index");
        rd(ifd_pkg::OFS_LOC, H, 32'h0000_0008, "rs loc");
        dec(32'h3362_1234, ifd_pkg::CLS_PLAIN, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RS);
        rd(ifd_pkg::OFS_OPND2, H, (32'h0000_1234 + gv(2)) & H, "rs index");
        wr(gra(9), 32'h0000_FFFC);
        for (int i = 0; i < 6; i++) begin
            wait_cycles <= 4'(i);
            dec(rx_ins[i], ifd_pkg::CLS_PLAIN, rx_sz[i], ifd_pkg::FMT_RX);
            rd(ifd_pkg::OFS_OPND2, (rx_sz[i] == ifd_pkg::SZ_FULL) ? F : H, rx_exp[i],
               "rx operand");
        end
        wr(ifd_pkg::OFS_STATUS_WORD, 32'h0000_000A);
        dec(32'h2160_0000, ifd_pkg::CLS_BRANCH_COND, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_OPND1, F, 32'h0000_0002, "cond mask");
        dec(32'h9E40_0000, ifd_pkg::CLS_IO, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_OPND1, H, gv(4), "io device");
        dec(32'hE1B0_0000, ifd_pkg::CLS_SVC, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_OPND1, F, 32'h0000_000B, "svc type");
        dec(32'hC0D0_0100, ifd_pkg::CLS_BRANCH_INDEX, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RS);
        rd(ifd_pkg::OFS_OPND1, H, gv(13), "bxh first");
        rd(ifd_pkg::OFS_OPND2, 32'hFFFF_0000, gv(14) << 16, "bxh second");
        rd(ifd_pkg::OFS_OPND3, H, gv(15), "bxh third");
        rd(ifd_pkg::OFS_CMD, 32'h0000_0010, 32'h0000_0000, "bxh legal");
        dec(32'hC0E0_0100, ifd_pkg::CLS_BRANCH_INDEX, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RS);
        rd(ifd_pkg::OFS_CMD, 32'h0000_0010, 32'h0000_0010, "bxh warn");
        dec(32'h8200_0000, ifd_pkg::CLS_ZERO_R1, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_CMD, 32'h0000_00E0, 32'h0000_0040, "zero r1 kept");
        dec(32'h8230_0000, ifd_pkg::CLS_ZERO_R1, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_CMD, 32'h0000_0020, 32'h0000_0020, "zero r1 warn");
        dec(32'h1C40_0000, ifd_pkg::CLS_EVEN_R1, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_CMD, 32'h0000_0008, 32'h0000_0000, "even r1 kept");
        dec(32'h1C50_0000, ifd_pkg::CLS_EVEN_R1, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_CMD, 32'h0000_0008, 32'h0000_0008, "even r1 warn");
        dec(32'h2A62_0000, ifd_pkg::CLS_FLOAT, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        chk("fp_sel", 32'(fp_sel), 32'h0000_0001);
        chk("fp_reg_sel", 32'(fp_reg_sel), 32'h0000_0006);
        rd(ifd_pkg::OFS_OPND1, F, 32'h0000_0000, "fp opnd1");
        dec(32'h2A72_0000, ifd_pkg::CLS_FLOAT, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_CMD, 32'h0000_0008, 32'h0000_0008, "fp odd warn");
        wr(ifd_pkg::OFS_STATUS_WORD, 32'h0000_1234);
        dec(32'h9555_0000, ifd_pkg::CLS_EXCHANGE, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(gra(5), H, 32'h0000_1234, "xchg same reg");
        rd(ifd_pkg::OFS_STATUS_WORD, H, 32'h0000_1234, "xchg same status");
        dec(32'h9556_0000, ifd_pkg::CLS_EXCHANGE, ifd_pkg::SZ_HALF, ifd_pkg::FMT_RR);
        rd(ifd_pkg::OFS_STATUS_WORD, H, gv(6), "xchg status");
        print_verdict();
    end
endmodule : testbench
